// file: tb/usb_device_irq_regs_chk.sv
// port-level assertions for the usb device interrupt register block
// bound to usb_device_irq_regs; sees only its ports
`timescale 1ns/1ps
`include "usb_irq_defines.vh"

module usb_device_irq_regs_chk #(
    parameter [`IDLE_CNT_W-1:0] SUSPEND_CYCLES = `SUSPEND_CYCLES
) (
    input logic               clk,
    input logic               rst_b,
    input logic               s_axi_awvalid,
    input logic               s_axi_awready,
    input logic               s_axi_wvalid,
    input logic               s_axi_wready,
    input logic [1:0]         s_axi_bresp,
    input logic               s_axi_bvalid,
    input logic               s_axi_bready,
    input logic [`ADDR_W-1:0] s_axi_araddr,
    input logic               s_axi_arvalid,
    input logic               s_axi_arready,
    input logic [31:0]        s_axi_rdata,
    input logic [1:0]         s_axi_rresp,
    input logic               s_axi_rvalid,
    input logic               s_axi_rready,
    input logic               usb_activity,
    input logic               usb_bus_reset,
    input logic               suspended,
    input logic               endpoint0_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    reg [`ADDR_W-1:0] last_ar;
    reg [15:0]        quiet_cnt;

    // raw count leads the synced view
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_ar <= '0;
            quiet_cnt <= 16'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready)
                last_ar <= s_axi_araddr;
            if (usb_activity || usb_bus_reset)
                quiet_cnt <= 16'h0;
            else if (quiet_cnt != 16'hffff)
                quiet_cnt <= quiet_cnt + 16'h1;
        end
    end

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_write_answer: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("bvalid timing");
    a_read_answer: assert property (s_rd_taken |=> !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("rvalid timing");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp not held");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("rdata not held");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write not blocked");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read not blocked");
    a_mask_fixed: assert property (s_axi_rvalid && last_ar == `OFS_ENABLE_STATE
        |-> s_axi_rdata[12] && s_axi_rdata[31:14] == 18'h0 && !s_axi_rdata[10])
        else $error("mask fixed bits");
    a_wo_zero: assert property (s_axi_rvalid && (last_ar == `OFS_ENABLE_SET
        || last_ar == `OFS_ENABLE_CLEAR) |-> s_axi_rdata == 32'h0)
        else $error("write-only read");
    a_unmapped_err: assert property (s_axi_rvalid && last_ar != `OFS_ENABLE_SET
        && last_ar != `OFS_ENABLE_CLEAR && last_ar != `OFS_ENABLE_STATE
        && last_ar != `OFS_PENDING_STATE |-> s_axi_rresp == `AXI_SLVERR)
        else $error("unmapped read");
    a_ep0_ready: assert property ($fell(usb_bus_reset) |-> ##[1:8] endpoint0_ready)
        else $error("ep0 not ready");
    a_suspend_early: assert property ($rose(suspended)
        |-> quiet_cnt >= SUSPEND_CYCLES)
        else $error("early suspend");
    a_suspend_late: assert property (quiet_cnt >= SUSPEND_CYCLES + 16'd5
        |-> suspended)
        else $error("late suspend");
endmodule

bind usb_device_irq_regs usb_device_irq_regs_chk #(
    .SUSPEND_CYCLES(SUSPEND_CYCLES)
) i_usb_device_irq_regs_chk (
    .clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .usb_activity(usb_activity),
    .usb_bus_reset(usb_bus_reset), .suspended(suspended),
    .endpoint0_ready(endpoint0_ready)
);

// file: tb/usb_device_irq_regs_test.sv
// self-checking bench for usb_device_irq_regs over AXI4-Lite
// needs usb_host_model and the bound checker
`timescale 1ns/1ps
`include "usb_irq_defines.vh"

module usb_device_irq_regs_test;
    localparam int SC = 20;
    localparam int LIMIT = 20000;
    logic                 clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic [`ADDR_W-1:0]   awaddr, araddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic [5:0]           flags [0:4];
    logic [1:0]           r;
    wire                  awready, wready, bvalid, arready, rvalid, irq;
    wire                  suspended, ep0_rdy, act, resume, sof, busrst;
    wire  [1:0]           bresp, rresp;
    wire  [31:0]          rdata;
    int                   n_fail, samples_checked, cycles;
    int                   bits [10] = '{0, 1, 2, 3, 4, 5, 8, 9, 11, 13};

    usb_device_irq_regs #(.SUSPEND_CYCLES(SC)) i_usb_device_irq_regs (
        .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .setup_received_flag(flags[0]),
        .bank0_received_flag(flags[1]), .bank1_received_flag(flags[2]),
        .transmit_done_flag(flags[3]), .stall_sent_flag(flags[4]),
        .usb_activity(act), .usb_resume(resume), .usb_frame_start(sof),
        .usb_bus_reset(busrst), .irq(irq), .suspended(suspended),
        .endpoint0_ready(ep0_rdy)
    );
    usb_host_model i_usb_host_model (
        .clk(clk), .usb_activity(act), .usb_resume(resume),
        .usb_frame_start(sof), .usb_bus_reset(busrst)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task wrap_up();
        if (n_fail == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            wrap_up();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
            n_fail++;
        end
    endtask

    task axi_write(input logic [7:0] a, input logic [31:0] d,
                   input logic [3:0] s, output logic [1:0] rr);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        rr = bresp;
        bready <= 1'b0;
    endtask

    task axi_read(input logic [7:0] a, output logic [31:0] d,
                  output logic [1:0] rr);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er = `AXI_OKAY);
        logic [1:0] rr;
        axi_write(a, d, 4'hf, rr);
        check(rr, er);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] ed,
            input logic [1:0] er = `AXI_OKAY);
        logic [31:0] d;
        logic [1:0]  rr;
        axi_read(a, d, rr);
        check(d, ed);
        check(rr, er);
    endtask

    task wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    initial begin
        rst_b = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata, wstrb} = '0;
        flags = '{default: 6'h0};
        wait_clk(12);
        rst_b <= 1'b1;
        rd(`OFS_ENABLE_STATE, 32'h1200);
        rd(`OFS_PENDING_STATE, 32'h0);
        rd(`OFS_ENABLE_SET, 32'h0);
        rd(`OFS_ENABLE_CLEAR, 32'h0);
        rd(8'h24, 32'h0, `AXI_SLVERR);
        wr(8'h24, 32'hffffffff, `AXI_SLVERR);
        wr(`OFS_ENABLE_SET, 32'hffffffff);
        rd(`OFS_ENABLE_STATE, 32'h3b3f);
        wr(`OFS_ENABLE_STATE, 32'h0);
        rd(`OFS_ENABLE_STATE, 32'h3b3f);
        wr(`OFS_ENABLE_CLEAR, 32'hffffffff);
        rd(`OFS_ENABLE_STATE, 32'h1000);
        foreach (bits[i]) begin
            wr(`OFS_ENABLE_SET, 32'h1 << bits[i]);
            wr(`OFS_ENABLE_SET, 32'h0);
            rd(`OFS_ENABLE_STATE, 32'h1000 | (32'h1 << bits[i]));
            wr(`OFS_ENABLE_CLEAR, 32'h0);
            rd(`OFS_ENABLE_STATE, 32'h1000 | (32'h1 << bits[i]));
            wr(`OFS_ENABLE_CLEAR, 32'h1 << bits[i]);
            rd(`OFS_ENABLE_STATE, 32'h1000);
        end
        // lane 0 only: events untouched
        axi_write(`OFS_ENABLE_SET, 32'h3b3f, 4'h1, r);
        rd(`OFS_ENABLE_STATE, 32'h103f);
        foreach (flags[k])
            for (int e = 0; e < 6; e++) begin
                flags[k][e] <= 1'b1;
                wait_clk(4);
                rd(`OFS_PENDING_STATE, 32'h1 << e);
                rd(`OFS_PENDING_STATE, 32'h1 << e);
                check(irq, 1);
                flags[k][e] <= 1'b0;
                wait_clk(4);
                check(irq, 0);
            end
        wr(`OFS_ENABLE_CLEAR, 32'h1);
        flags[2][0] <= 1'b1;
        wait_clk(4);
        check(irq, 0);
        rd(`OFS_PENDING_STATE, 32'h1);
        flags[2][0] <= 1'b0;
        wr(`OFS_ENABLE_SET, 32'h0200);
        i_usb_host_model.hold_line(0, 4);
        wait_clk(6);
        check(irq, 1);
        rd(`OFS_PENDING_STATE, 32'h2200);
        rd(`OFS_PENDING_STATE, 32'h0);
        wait_clk(3);
        check(irq, 0);
        repeat (2) begin
            i_usb_host_model.hold_line(1, 4);
            wait_clk(6);
            check(irq, 0);
            rd(`OFS_PENDING_STATE, 32'h0800);
        end
        check(ep0_rdy, 0);
        i_usb_host_model.hold_line(2, 6);
        wait_clk(8);
        check(ep0_rdy, 1);
        check(irq, 1);
        rd(`OFS_PENDING_STATE, 32'h3000);
        i_usb_host_model.set_quiet(1'b1);
        wait_clk(SC / 2);
        check(suspended, 0);
        wait_clk(SC);
        check(suspended, 1);
        rd(`OFS_PENDING_STATE, 32'h0100);
        i_usb_host_model.set_quiet(1'b0);
        wait_clk(6);
        check(suspended, 0);
        // mid-run reset
        rst_b <= 1'b0;
        wait_clk(3);
        rst_b <= 1'b1;
        rd(`OFS_ENABLE_STATE, 32'h1200);
        check(ep0_rdy, 0);
        wrap_up();
    end
endmodule

// file: tb/usb_host_model.sv
// behavioural usb host: bus traffic, resume, frame start, bus reset
// levels change just after clk edges; device synchronises them
`timescale 1ns/1ps

module usb_host_model (
    input  wire logic clk,
    output logic      usb_activity,
    output logic      usb_resume,
    output logic      usb_frame_start,
    output logic      usb_bus_reset
);
    initial {usb_activity, usb_resume, usb_frame_start, usb_bus_reset} = 4'h8;

    // which: 0 resume, 1 frame start, 2 bus reset; held >= 3 clocks
    task hold_line(input int which, input int cycles);
        @(posedge clk);
        case (which)
            0: usb_resume <= 1'b1;
            1: usb_frame_start <= 1'b1;
            default: usb_bus_reset <= 1'b1;
        endcase
        repeat (cycles) @(posedge clk);
        usb_resume <= 1'b0;
        usb_frame_start <= 1'b0;
        usb_bus_reset <= 1'b0;
    endtask

    task set_quiet(input logic quiet);
        @(posedge clk);
        usb_activity <= !quiet;
    endtask
endmodule

// file: verilog/axi_lite_slave.v
// AXI4-Lite slave front end: one write and one read outstanding
// the register core decodes the held address in the same cycle
`timescale 1ns/1ps
`include "usb_irq_defines.vh"

module axi_lite_slave (
    input  wire                clk,
    input  wire                rst_b,
    input  wire [`ADDR_W-1:0]  s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output reg                 s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output reg                 s_axi_wready,
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    input  wire [`ADDR_W-1:0]  s_axi_araddr,
    input  wire                s_axi_arvalid,
    output reg                 s_axi_arready,
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready,
    output wire                wr_en,
    output reg  [`ADDR_W-1:0]  wr_addr,
    output reg  [31:0]         wr_data,
    output reg  [3:0]          wr_strb,
    input  wire                wr_ok,
    output wire                rd_en,
    output reg  [`ADDR_W-1:0]  rd_addr,
    input  wire [31:0]         rd_data,
    input  wire                rd_ok
);

    // ready low means the channel holds its item
    assign wr_en = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign rd_en = ~s_axi_arready & ~s_axi_rvalid;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_OKAY;
            wr_addr       <= {`ADDR_W{1'b0}};
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `AXI_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            rd_addr       <= {`ADDR_W{1'b0}};
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                rd_addr       <= s_axi_araddr;
                s_axi_arready <= 1'b0;
            end
            if (rd_en) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// file: verilog/bus_idle_timer.v
// bus idle watchdog: flags suspend after a quiet spell
// activity input is already synchronised to clk
`timescale 1ns/1ps
`include "usb_irq_defines.vh"

module bus_idle_timer #(
    parameter [`IDLE_CNT_W-1:0] IDLE_CYCLES = `SUSPEND_CYCLES
) (
    input  wire  clk,
    input  wire  rst_b,
    input  wire  activity,
    output reg   suspend_pulse,
    output reg   suspended
);

    reg [`IDLE_CNT_W-1:0] idle_cnt;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_cnt      <= {`IDLE_CNT_W{1'b0}};
            suspend_pulse <= 1'b0;
            suspended     <= 1'b0;
        end else begin
            suspend_pulse <= 1'b0;
            if (activity) begin
                idle_cnt  <= {`IDLE_CNT_W{1'b0}};
                suspended <= 1'b0;
            end else if (!suspended) begin
                // one pulse per quiet spell, then hold until traffic
                if (idle_cnt == IDLE_CYCLES - 1'b1) begin
                    suspend_pulse <= 1'b1;
                    suspended     <= 1'b1;
                    idle_cnt      <= {`IDLE_CNT_W{1'b0}};
                end else begin
                    idle_cnt <= idle_cnt + 1'b1;
                end
            end
        end
    end

endmodule

// file: verilog/usb_device_irq_regs.v
// interrupt enable, mask and status registers of a usb device port
// bus-side event lines are asynchronous; endpoint flags share clk
`timescale 1ns/1ps
`include "usb_irq_defines.vh"

// Operation
// - A one written to an endpoint bit of enable-set sets that mask bit.
// - Ones at bits 8, 9, 11, 13 of enable-set enable those events.
// - A one written to an endpoint bit of enable-clear clears that mask bit.
// - Ones at bits 8, 9, 11, 13 of enable-clear disable those events.
// - The mask register reads one for each enabled endpoint interrupt.
// - The mask register reads the enabled state of the four event bits.
// - Mask bit 12 always reads one and cannot be disabled.
// - The resume mask bit is enabled out of reset.
// - An endpoint status bit rises on any of its five endpoint flags.
// - An endpoint status bit holds until its flag is cleared, not on read.
// - Suspend status is set after 3 ms with no bus activity.
// - Resume status is set when a resume is seen on the bus.
// - Frame start status is set on every start-of-frame token.
// - Bus reset done status is set at reset end, readying endpoint 0.
// - Wakeup status is set on a host resume or reset and held.
module usb_device_irq_regs #(
    parameter [`IDLE_CNT_W-1:0] SUSPEND_CYCLES = `SUSPEND_CYCLES
) (
    input  wire                       clk,
    input  wire                       rst_b,
    input  wire [`ADDR_W-1:0]         s_axi_awaddr,
    input  wire                       s_axi_awvalid,
    output wire                       s_axi_awready,
    input  wire [31:0]                s_axi_wdata,
    input  wire [3:0]                 s_axi_wstrb,
    input  wire                       s_axi_wvalid,
    output wire                       s_axi_wready,
    output wire [1:0]                 s_axi_bresp,
    output wire                       s_axi_bvalid,
    input  wire                       s_axi_bready,
    input  wire [`ADDR_W-1:0]         s_axi_araddr,
    input  wire                       s_axi_arvalid,
    output wire                       s_axi_arready,
    output wire [31:0]                s_axi_rdata,
    output wire [1:0]                 s_axi_rresp,
    output wire                       s_axi_rvalid,
    input  wire                       s_axi_rready,
    input  wire [`NUM_ENDPOINTS-1:0]  setup_received_flag,
    input  wire [`NUM_ENDPOINTS-1:0]  bank0_received_flag,
    input  wire [`NUM_ENDPOINTS-1:0]  bank1_received_flag,
    input  wire [`NUM_ENDPOINTS-1:0]  transmit_done_flag,
    input  wire [`NUM_ENDPOINTS-1:0]  stall_sent_flag,
    input  wire                       usb_activity,
    input  wire                       usb_resume,
    input  wire                       usb_frame_start,
    input  wire                       usb_bus_reset,
    output reg                        irq,
    output wire                       suspended,
    output reg                        endpoint0_ready
);

    localparam NUM_PINS = 4;
    localparam PIN_ACT  = 0;
    localparam PIN_RSM  = 1;
    localparam PIN_SOF  = 2;
    localparam PIN_RST  = 3;

    wire                 wr_en;
    wire [`ADDR_W-1:0]   wr_addr;
    wire [31:0]          wr_data;
    wire [3:0]           wr_strb;
    wire                 rd_en;
    wire [`ADDR_W-1:0]   rd_addr;
    reg  [31:0]          rd_data;
    reg                  rd_ok;
    reg                  wr_ok;

    wire [NUM_PINS-1:0]  pin_in;
    reg  [NUM_PINS-1:0]  pin_meta;
    reg  [NUM_PINS-1:0]  pin_sync;
    reg  [NUM_PINS-1:0]  pin_prev;
    wire [NUM_PINS-1:0]  pin_rise;
    wire                 pin_reset_fall;

    wire                 suspend_pulse;
    wire [31:0]          lane_mask;
    wire [`IRQ_W-1:0]    wr_bits;
    wire                 wr_set;
    wire                 wr_clear;
    wire                 rd_status;

    reg  [`IRQ_W-1:0]    mask;
    reg  [`IRQ_W-1:0]    next_mask;
    reg  [`IRQ_W-1:0]    events;
    reg  [`IRQ_W-1:0]    next_events;
    reg  [`IRQ_W-1:0]    event_set;
    wire [`NUM_ENDPOINTS-1:0] ep_pending;
    wire [`IRQ_W-1:0]    mask_view;
    wire [`IRQ_W-1:0]    status_view;

    axi_lite_slave u_bus (
        .clk           (clk),
        .rst_b         (rst_b),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_ok         (wr_ok),
        .rd_en         (rd_en),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    // bus-side lines come from the transceiver clock, so two stages each
    assign pin_in[PIN_ACT] = usb_activity;
    assign pin_in[PIN_RSM] = usb_resume;
    assign pin_in[PIN_SOF] = usb_frame_start;
    assign pin_in[PIN_RST] = usb_bus_reset;

    genvar p;
    generate
        for (p = 0; p < NUM_PINS; p = p + 1) begin : g_sync
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    pin_meta[p] <= 1'b0;
                    pin_sync[p] <= 1'b0;
                    pin_prev[p] <= 1'b0;
                end else begin
                    pin_meta[p] <= pin_in[p];
                    pin_sync[p] <= pin_meta[p];
                    pin_prev[p] <= pin_sync[p];
                end
            end
            assign pin_rise[p] = pin_sync[p] & ~pin_prev[p];
        end
    endgenerate

    assign pin_reset_fall = pin_prev[PIN_RST] & ~pin_sync[PIN_RST];

    // a bus reset also counts as traffic for the idle watch
    bus_idle_timer #(
        .IDLE_CYCLES (SUSPEND_CYCLES)
    ) u_idle (
        .clk           (clk),
        .rst_b         (rst_b),
        .activity      (pin_sync[PIN_ACT] | pin_sync[PIN_RST]),
        .suspend_pulse (suspend_pulse),
        .suspended     (suspended)
    );

    // endpoint status follows the flags; clearing is done on the flags
    genvar e;
    generate
        for (e = 0; e < `NUM_ENDPOINTS; e = e + 1) begin : g_ep
            assign ep_pending[e] = setup_received_flag[e]
                                 | bank0_received_flag[e]
                                 | bank1_received_flag[e]
                                 | transmit_done_flag[e]
                                 | stall_sent_flag[e];
        end
    endgenerate

    // byte enables gate which bits a write may touch
    assign lane_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                        {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign wr_bits   = wr_data[`IRQ_W-1:0] & lane_mask[`IRQ_W-1:0]
                     & `MASK_WRITABLE;
    assign wr_set    = wr_en & (wr_addr == `OFS_ENABLE_SET);
    assign wr_clear  = wr_en & (wr_addr == `OFS_ENABLE_CLEAR);
    assign rd_status = rd_en & (rd_addr == `OFS_PENDING_STATE);

    always @* begin
        next_mask = mask;
        if (wr_set) begin
            next_mask = mask | wr_bits;
        end
        if (wr_clear) begin
            next_mask = mask & ~wr_bits;
        end
    end

    always @* begin
        event_set = {`IRQ_W{1'b0}};
        event_set[`BIT_SUSPEND]        = suspend_pulse;
        event_set[`BIT_RESUME]         = pin_rise[PIN_RSM];
        event_set[`BIT_FRAME_START]    = pin_rise[PIN_SOF];
        event_set[`BIT_BUS_RESET_DONE] = pin_reset_fall;
        event_set[`BIT_WAKEUP]         = pin_rise[PIN_RSM]
                                       | pin_rise[PIN_RST];
    end

    // a status read clears the sticky events, but a same-cycle event survives
    always @* begin
        next_events = events;
        if (rd_status) begin
            next_events = {`IRQ_W{1'b0}};
        end
        next_events = (next_events | event_set) & `EVENT_BITS;
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask   <= `MASK_RESET;
            events <= {`IRQ_W{1'b0}};
        end else begin
            mask   <= next_mask;
            events <= next_events;
        end
    end

    assign mask_view   = (mask & `MASK_WRITABLE) | `MASK_FORCED;
    assign status_view = events
                       | {{(`IRQ_W-`NUM_ENDPOINTS){1'b0}}, ep_pending};

    // registered, so the line lags a status change by one cycle
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_view & mask_view);
        end
    end

    // endpoint 0 is held off while the bus is in reset
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            endpoint0_ready <= 1'b0;
        end else if (pin_sync[PIN_RST]) begin
            endpoint0_ready <= 1'b0;
        end else if (pin_reset_fall) begin
            endpoint0_ready <= 1'b1;
        end
    end

    always @* begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (rd_addr)
            `OFS_ENABLE_SET: begin
                rd_data = 32'h0000_0000;
            end
            `OFS_ENABLE_CLEAR: begin
                rd_data = 32'h0000_0000;
            end
            `OFS_ENABLE_STATE: begin
                rd_data = {{(32-`IRQ_W){1'b0}}, mask_view};
            end
            `OFS_PENDING_STATE: begin
                rd_data = {{(32-`IRQ_W){1'b0}}, status_view};
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // read-only words accept and drop writes; unmapped ones error
    always @* begin
        case (wr_addr)
            `OFS_ENABLE_SET:    wr_ok = 1'b1;
            `OFS_ENABLE_CLEAR:  wr_ok = 1'b1;
            `OFS_ENABLE_STATE:  wr_ok = 1'b1;
            `OFS_PENDING_STATE: wr_ok = 1'b1;
            default:            wr_ok = 1'b0;
        endcase
    end

endmodule

// file: verilog/usb_irq_defines.vh
// constants for the usb device interrupt register block
// assumes a 10 MHz bus clock and an 8-bit AXI4-Lite byte address
`ifndef USB_IRQ_DEFINES_VH
`define USB_IRQ_DEFINES_VH

`define ADDR_W              8
`define OFS_ENABLE_SET      8'h10
`define OFS_ENABLE_CLEAR    8'h14
`define OFS_ENABLE_STATE    8'h18
`define OFS_PENDING_STATE   8'h1c

`define NUM_ENDPOINTS       6
`define IRQ_W               14
`define BIT_SUSPEND         8
`define BIT_RESUME          9
`define BIT_FRAME_START     11
`define BIT_BUS_RESET_DONE  12
`define BIT_WAKEUP          13

// mask bits that software may set or clear; bit 12 is fixed at one
`define MASK_WRITABLE       14'h2b3f
`define MASK_RESET          14'h0200
`define MASK_FORCED         14'h1000
// status bits held sticky in this block, cleared by a status read
`define EVENT_BITS          14'h3b00

`define AXI_OKAY            2'h0
`define AXI_SLVERR          2'h2

`define CLK_KHZ             10000
`define SUSPEND_TIME_US     3000
`define SUSPEND_CYCLES      ((`SUSPEND_TIME_US * `CLK_KHZ) / 1000)
`define IDLE_CNT_W          16

`endif
